// File: logic/dcs_pkg.sv
package dcs_pkg;

    // clock and timing
    localparam int CLK_PERIOD_PS = 5000; // 200 MHz system clock
    localparam int CAL_TIME_NS = 1000; // least time for i/o calibration
    localparam int CAL_CYCLES = (CAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int IRQ_HOLD_CYCLES = 4; // interrupt level stretch length

    // register byte offsets
    localparam logic [11:0] REG_CTRL = 12'h000; // control
    localparam logic [11:0] REG_STATUS = 12'h004; // live status
    localparam logic [11:0] REG_EVENT = 12'h008; // sticky events, write one to clear
    localparam logic [11:0] REG_ECC_CNT = 12'h00C; // ecc event count

    // control fields
    localparam int CTRL_CAL_EN_BIT = 0; // allow calibration after lock
    localparam int CTRL_RECAL_BIT = 1; // write one to restart calibration
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    // status fields
    localparam int STAT_LOCKED_BIT = 0;
    localparam int STAT_CAL_DONE_BIT = 1;
    localparam int STAT_FAB_LOCK_BIT = 2;

    // event fields
    localparam int EVT_LOCK_BIT = 0;
    localparam int EVT_LOST_BIT = 1;
    localparam int EVT_ECC_BIT = 2;
    localparam int EVT_CAL_BIT = 3;
    localparam int EVT_FIC_BIT = 4;
    localparam int EVT_W = 5;

    localparam logic [15:0] ECC_CNT_MAX = 16'hFFFF;

    // calibration sequencer states
    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_RUN = 3'b010,
        CAL_DONE = 3'b100
    } dcs_cal_t;

endpackage

// File: logic/dcs_irq_stretch.sv
`timescale 1ns/10ps
module dcs_irq_stretch
    import dcs_pkg::*;
#(
    parameter bit ENABLE = 1'b1, // interrupt group built in
    parameter int HOLD = IRQ_HOLD_CYCLES // cycles the level stands
) (
    input wire logic sys_clk, // system clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic evt, // one-cycle trigger
    output logic irq // stretched interrupt level
);

    logic [7:0] cnt_ff; // remaining hold cycles
    logic [7:0] nxt_cnt;

    // reload on every event, otherwise count down to zero
    always_comb begin
        nxt_cnt = cnt_ff;
        if (evt && ENABLE) begin
            nxt_cnt = 8'(HOLD);
        end else if (cnt_ff != 8'h00) begin
            nxt_cnt = cnt_ff - 8'h01;
        end
    end

    // register the counter
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cnt_ff <= 8'h00;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign irq = ENABLE && (cnt_ff != 8'h00);

    a_irq_absent: assert property (@(posedge sys_clk) !ENABLE |-> !irq)
        else $error("interrupt seen while group is disabled");
    a_irq_held: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(irq) |-> irq[*4])
        else $error("interrupt level dropped too early");

endmodule

// File: logic/dcs_lane.sv
`timescale 1ns/10ps
module dcs_lane #(
    parameter int W = 8 // data bits in this lane
) (
    input wire logic sys_clk, // system clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic wr_en, // drive this cycle's write data
    input wire logic [W-1:0] wr_data, // user write data
    input wire logic wr_mask, // user byte mask
    output logic [W-1:0] rd_data, // captured read data
    input wire logic [W-1:0] dq_i, // data pin level
    output logic [W-1:0] dq_o, // data pin drive
    output logic dq_oe, // data pin enable
    input wire logic dm_i, // mask pin level
    output logic dm_o, // mask pin drive
    output logic dm_oe, // mask pin enable
    input wire logic dqs_i, // strobe p level
    output logic dqs_o, // strobe p drive
    output logic dqs_oe, // strobe p enable
    input wire logic dqs_n_i, // strobe n level
    output logic dqs_n_o, // strobe n drive
    output logic dqs_n_oe // strobe n enable
);

    logic [W-1:0] dq_o_ff; // registered drive value
    logic [W-1:0] nxt_dq_o;
    logic oe_ff; // registered enable
    logic nxt_oe;
    logic dm_ff; // registered mask
    logic nxt_dm;
    logic [W-1:0] rd_ff; // captured read data
    logic [W-1:0] nxt_rd;
    logic strobe_in; // differential strobe high and mask pin low while not driving

    assign strobe_in = dqs_i && !dqs_n_i && !oe_ff && !dm_i;

    // next drive and capture values
    always_comb begin
        nxt_oe = wr_en;
        nxt_dq_o = wr_en ? wr_data : dq_o_ff;
        nxt_dm = wr_en ? wr_mask : dm_ff;
        nxt_rd = strobe_in ? dq_i : rd_ff;
    end

    // register lane state
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            dq_o_ff <= '0;
            oe_ff <= 1'b0;
            dm_ff <= 1'b0;
            rd_ff <= '0;
        end else begin
            dq_o_ff <= nxt_dq_o;
            oe_ff <= nxt_oe;
            dm_ff <= nxt_dm;
            rd_ff <= nxt_rd;
        end
    end

    assign dq_o = dq_o_ff;
    assign dq_oe = oe_ff;
    assign dm_o = dm_ff;
    assign dm_oe = oe_ff;
    assign dqs_o = oe_ff;
    assign dqs_oe = oe_ff;
    assign dqs_n_o = !oe_ff;
    assign dqs_n_oe = oe_ff;
    assign rd_data = rd_ff;

endmodule

// File: logic/dcs_shell.sv
`timescale 1ns/10ps
// Notes on behaviour
// - lock status follows internal pll lock
// - fabric lock input gates calibration only when option set
// - interrupt outputs exist only when enabled; here the ports stay, held low when IRQ_ENABLE is 0
// - pulse interrupt when pll gains lock
// - pulse interrupt when held lock is lost
// - interrupt on every ecc event
// - interrupt when i/o calibration completes
// - interrupt on fabric bus protocol error
// - data, mask, strobe, ecc widths follow phy width
// - second strobe match pair only at 32 bits
module dcs_shell
    import dcs_pkg::*;
#(
    parameter int PHY_WIDTH = 32, // 32, 16 or 8
    parameter bit USE_FABRIC_PLL_LOCK = 1'b0, // use_fabric_pll_lock_option
    parameter bit IRQ_ENABLE = 1'b1, // interrupt group built in
    localparam int NL = PHY_WIDTH / 8, // byte lanes
    localparam int ECC_W = PHY_WIDTH / 8 // ecc data bits
) (
    input wire logic sys_clk, // fabric_if_clock
    input wire logic rstn, // controller reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic pll_lock_raw, // internal ddr pll lock detector
    input wire logic fabric_pll_locked_in, // fabric pll lock
    input wire logic ecc_event, // ecc event pulse from datapath
    input wire logic fab_proto_err, // fabric protocol error pulse
    output logic ddr_pll_locked, // pll lock status
    output logic pll_locked_irq, // pll gained lock
    output logic pll_lock_lost_irq, // pll lost lock
    output logic ecc_irq, // ecc event
    output logic io_calibration_done_irq, // calibration done
    output logic fabric_protocol_error_irq, // fabric protocol error
    input wire logic wr_en, // user drive enable
    input wire logic [PHY_WIDTH-1:0] wr_data, // user write data
    input wire logic [NL-1:0] wr_mask, // user byte masks
    output logic [PHY_WIDTH-1:0] rd_data, // captured read data
    input wire logic [ECC_W-1:0] ecc_wr_data, // ecc write data
    input wire logic ecc_wr_mask, // ecc mask
    output logic [ECC_W-1:0] ecc_rd_data, // ecc read data
    input wire logic [PHY_WIDTH-1:0] dq_i, // data pins in
    output logic [PHY_WIDTH-1:0] dq_o, // data pins out
    output logic [NL-1:0] dq_oe, // data enable per lane
    input wire logic [NL-1:0] dm_i, // mask pins in
    output logic [NL-1:0] dm_o, // mask pins out
    output logic [NL-1:0] dm_oe, // mask enable
    input wire logic [NL-1:0] dqs_i, // strobe p in
    output logic [NL-1:0] dqs_o, // strobe p out
    output logic [NL-1:0] dqs_oe, // strobe p enable
    input wire logic [NL-1:0] dqs_n_i, // strobe n in
    output logic [NL-1:0] dqs_n_o, // strobe n out
    output logic [NL-1:0] dqs_n_oe, // strobe n enable
    input wire logic [ECC_W-1:0] dq_ecc_i, // ecc data in
    output logic [ECC_W-1:0] dq_ecc_o, // ecc data out
    output logic dq_ecc_oe, // ecc data enable
    input wire logic dm_ecc_i, // ecc mask in
    output logic dm_ecc_o, // ecc mask out
    output logic dm_ecc_oe, // ecc mask enable
    input wire logic dqs_ecc_i, // ecc strobe p in
    output logic dqs_ecc_o, // ecc strobe p out
    output logic dqs_ecc_oe, // ecc strobe p enable
    input wire logic dqs_ecc_n_i, // ecc strobe n in
    output logic dqs_ecc_n_o, // ecc strobe n out
    output logic dqs_ecc_n_oe, // ecc strobe n enable
    input wire logic strobe_match_fifo0_in, // strobe match return 0
    output logic strobe_match_fifo0_out, // strobe match launch 0
    input wire logic strobe_match_fifo1_in, // strobe match return 1
    output logic strobe_match_fifo1_out, // strobe match launch 1
    input wire logic strobe_match_ecc_in, // ecc strobe match return
    output logic strobe_match_ecc_out // ecc strobe match launch
);

    ////////////////////////////////////////////////////////////////////////
    // pll lock tracking

    logic locked_ff; // registered lock status
    logic locked_d_ff; // previous cycle lock
    logic nxt_locked;
    logic lock_rise; // lock gained this cycle
    logic lock_fall; // lock lost this cycle
    logic eff_lock; // lock qualified by fabric option

    // sample the internal lock detector
    always_comb begin
        nxt_locked = pll_lock_raw;
    end

    // register lock history
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            locked_ff <= 1'b0;
            locked_d_ff <= 1'b0;
        end else begin
            locked_ff <= nxt_locked;
            locked_d_ff <= locked_ff;
        end
    end

    assign ddr_pll_locked = locked_ff;
    assign lock_rise = locked_ff && !locked_d_ff;
    assign lock_fall = !locked_ff && locked_d_ff;
    // fabric lock only gates calibration when the option is built in
    assign eff_lock = locked_ff && (!USE_FABRIC_PLL_LOCK || fabric_pll_locked_in);

    ////////////////////////////////////////////////////////////////////////
    // register state and apb decode

    logic [31:0] ctrl_ff; // control register
    logic [31:0] nxt_ctrl;
    logic [EVT_W-1:0] evt_ff; // sticky events
    logic [EVT_W-1:0] nxt_evt;
    logic [15:0] ecc_cnt_ff; // saturating ecc count
    logic [15:0] nxt_ecc_cnt;
    logic [31:0] prdata_ff; // read data register
    logic [31:0] nxt_prdata;
    logic [EVT_W-1:0] evt_set; // events raised this cycle
    logic addr_hit; // address maps a register
    logic wr_acc; // write access phase
    logic recal; // software restart of calibration
    logic cal_done_pulse; // calibration finished this cycle
    dcs_cal_t cal_ff; // calibration state
    dcs_cal_t nxt_cal;
    logic [15:0] cal_cnt_ff; // calibration timer
    logic [15:0] nxt_cal_cnt;

    assign addr_hit = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
                      (paddr == REG_EVENT) || (paddr == REG_ECC_CNT);
    assign wr_acc = psel && penable && pwrite && addr_hit;
    assign recal = wr_acc && (paddr == REG_CTRL) && pwdata[CTRL_RECAL_BIT];
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;
    assign prdata = prdata_ff;

    assign evt_set[EVT_LOCK_BIT] = lock_rise;
    assign evt_set[EVT_LOST_BIT] = lock_fall;
    assign evt_set[EVT_ECC_BIT] = ecc_event;
    assign evt_set[EVT_CAL_BIT] = cal_done_pulse;
    assign evt_set[EVT_FIC_BIT] = fab_proto_err;

    // register writes, sticky events and read mux
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_evt = evt_ff;
        nxt_ecc_cnt = ecc_cnt_ff;
        nxt_prdata = prdata_ff;
        if (wr_acc && (paddr == REG_CTRL)) begin
            nxt_ctrl = {31'h0000_0000, pwdata[CTRL_CAL_EN_BIT]};
        end
        // clear first, then set, so a new event is never lost
        if (wr_acc && (paddr == REG_EVENT)) begin
            nxt_evt = evt_ff & ~pwdata[EVT_W-1:0];
        end
        nxt_evt = nxt_evt | evt_set;
        if (ecc_event && (ecc_cnt_ff != ECC_CNT_MAX)) begin
            nxt_ecc_cnt = ecc_cnt_ff + 16'h0001;
        end
        // read data prepared in the setup cycle
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                REG_CTRL: nxt_prdata = ctrl_ff;
                REG_STATUS: nxt_prdata = {29'h0000_0000, fabric_pll_locked_in,
                                          cal_ff == CAL_DONE, locked_ff};
                REG_EVENT: nxt_prdata = {27'h0000_0000, evt_ff};
                REG_ECC_CNT: nxt_prdata = {16'h0000, ecc_cnt_ff};
                default: nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    // register file flops
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ctrl_ff <= CTRL_RESET;
            evt_ff <= '0;
            ecc_cnt_ff <= 16'h0000;
            prdata_ff <= 32'h0000_0000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            evt_ff <= nxt_evt;
            ecc_cnt_ff <= nxt_ecc_cnt;
            prdata_ff <= nxt_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // i/o calibration sequencer

    // start after qualified lock, time the calibration, restart on loss
    always_comb begin
        nxt_cal = cal_ff;
        nxt_cal_cnt = cal_cnt_ff;
        cal_done_pulse = 1'b0;
        unique case (cal_ff)
            CAL_IDLE: begin
                nxt_cal_cnt = 16'h0000;
                if (eff_lock && ctrl_ff[CTRL_CAL_EN_BIT]) begin
                    nxt_cal = CAL_RUN;
                end
            end
            CAL_RUN: begin
                if (!eff_lock || recal) begin
                    nxt_cal = CAL_IDLE;
                end else if (cal_cnt_ff == 16'(CAL_CYCLES - 1)) begin
                    nxt_cal = CAL_DONE;
                    cal_done_pulse = 1'b1;
                end else begin
                    nxt_cal_cnt = cal_cnt_ff + 16'h0001;
                end
            end
            CAL_DONE: begin
                if (!eff_lock || recal) begin
                    nxt_cal = CAL_IDLE;
                end
            end
            default: nxt_cal = CAL_IDLE;
        endcase
    end

    // register the sequencer
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cal_ff <= CAL_IDLE;
            cal_cnt_ff <= 16'h0000;
        end else begin
            cal_ff <= nxt_cal;
            cal_cnt_ff <= nxt_cal_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt outputs

    dcs_irq_stretch #(.ENABLE(IRQ_ENABLE), .HOLD(IRQ_HOLD_CYCLES)) u_irq_lock (
        .sys_clk(sys_clk), .rstn(rstn), .evt(lock_rise), .irq(pll_locked_irq));
    dcs_irq_stretch #(.ENABLE(IRQ_ENABLE), .HOLD(IRQ_HOLD_CYCLES)) u_irq_lost (
        .sys_clk(sys_clk), .rstn(rstn), .evt(lock_fall), .irq(pll_lock_lost_irq));
    dcs_irq_stretch #(.ENABLE(IRQ_ENABLE), .HOLD(IRQ_HOLD_CYCLES)) u_irq_ecc (
        .sys_clk(sys_clk), .rstn(rstn), .evt(ecc_event), .irq(ecc_irq));
    dcs_irq_stretch #(.ENABLE(IRQ_ENABLE), .HOLD(IRQ_HOLD_CYCLES)) u_irq_cal (
        .sys_clk(sys_clk), .rstn(rstn), .evt(cal_done_pulse),
        .irq(io_calibration_done_irq));
    dcs_irq_stretch #(.ENABLE(IRQ_ENABLE), .HOLD(IRQ_HOLD_CYCLES)) u_irq_fic (
        .sys_clk(sys_clk), .rstn(rstn), .evt(fab_proto_err),
        .irq(fabric_protocol_error_irq));

    ////////////////////////////////////////////////////////////////////////
    // dram pin lanes, sized from the phy width

    for (genvar g = 0; g < NL; g++) begin : g_lane
        dcs_lane #(.W(8)) u_lane (
            .sys_clk(sys_clk), .rstn(rstn), .wr_en(wr_en),
            .wr_data(wr_data[g*8 +: 8]), .wr_mask(wr_mask[g]),
            .rd_data(rd_data[g*8 +: 8]), .dq_i(dq_i[g*8 +: 8]),
            .dq_o(dq_o[g*8 +: 8]), .dq_oe(dq_oe[g]), .dm_i(dm_i[g]),
            .dm_o(dm_o[g]), .dm_oe(dm_oe[g]), .dqs_i(dqs_i[g]),
            .dqs_o(dqs_o[g]), .dqs_oe(dqs_oe[g]), .dqs_n_i(dqs_n_i[g]),
            .dqs_n_o(dqs_n_o[g]), .dqs_n_oe(dqs_n_oe[g]));
    end

    dcs_lane #(.W(ECC_W)) u_ecc_lane (
        .sys_clk(sys_clk), .rstn(rstn), .wr_en(wr_en), .wr_data(ecc_wr_data),
        .wr_mask(ecc_wr_mask), .rd_data(ecc_rd_data), .dq_i(dq_ecc_i),
        .dq_o(dq_ecc_o), .dq_oe(dq_ecc_oe), .dm_i(dm_ecc_i), .dm_o(dm_ecc_o),
        .dm_oe(dm_ecc_oe), .dqs_i(dqs_ecc_i), .dqs_o(dqs_ecc_o),
        .dqs_oe(dqs_ecc_oe), .dqs_n_i(dqs_ecc_n_i), .dqs_n_o(dqs_ecc_n_o),
        .dqs_n_oe(dqs_ecc_n_oe));

    ////////////////////////////////////////////////////////////////////////
    // strobe timing-match loop registers

    logic [2:0] match_ff; // loop-back flops
    logic [2:0] nxt_match;

    // the second pair and the ecc pair only exist at full width
    always_comb begin
        nxt_match[0] = strobe_match_fifo0_in;
        nxt_match[1] = (PHY_WIDTH == 32) && strobe_match_fifo1_in;
        nxt_match[2] = (PHY_WIDTH == 32) && strobe_match_ecc_in;
    end

    // register the loops
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            match_ff <= 3'h0;
        end else begin
            match_ff <= nxt_match;
        end
    end

    assign strobe_match_fifo0_out = match_ff[0];
    assign strobe_match_fifo1_out = match_ff[1];
    assign strobe_match_ecc_out = match_ff[2];

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_lock_follow: assert property ($past(rstn) |-> ddr_pll_locked == $past(pll_lock_raw))
        else $error("lock status does not follow pll");
    a_fab_gate: assert property (!USE_FABRIC_PLL_LOCK && locked_ff |-> eff_lock)
        else $error("fabric lock gated without option");
    a_lock_irq: assert property ($rose(ddr_pll_locked) |=> pll_locked_irq || !IRQ_ENABLE)
        else $error("no interrupt on lock");
    a_lost_irq: assert property ($fell(ddr_pll_locked) |=> pll_lock_lost_irq || !IRQ_ENABLE)
        else $error("no interrupt on lock loss");
    a_ecc_irq: assert property (ecc_event |=> ecc_irq || !IRQ_ENABLE)
        else $error("no interrupt on ecc event");
    a_cal_irq: assert property (cal_ff == CAL_RUN ##1 cal_ff == CAL_DONE
        |=> io_calibration_done_irq || !IRQ_ENABLE)
        else $error("no interrupt on calibration done");
    a_fic_irq: assert property (fab_proto_err |=> fabric_protocol_error_irq || !IRQ_ENABLE)
        else $error("no interrupt on protocol error");
    a_match_narrow: assert property (PHY_WIDTH != 32 |-> !strobe_match_fifo1_out)
        else $error("second strobe match active at narrow width");
    a_reset_low: assert property (@(posedge sys_clk) disable iff (1'b0)
        !rstn |=> !ddr_pll_locked && !pll_locked_irq && !ecc_irq)
        else $error("outputs not low after reset");

    c_cal_done: cover property (cal_ff == CAL_RUN ##1 cal_ff == CAL_DONE);
    c_lock_lost: cover property ($fell(ddr_pll_locked));
    c_evt_clear: cover property (wr_acc && paddr == REG_EVENT && ecc_event);

endmodule

// File: tb/dcs_far_model.sv
`timescale 1ns/10ps
// far side of the pins: dram device and strobe return paths
module dcs_far_model (
    input wire logic sys_clk, // system clock
    input wire logic [31:0] dq_o, // data driven by the controller
    input wire logic [3:0] dq_oe, // data lane enables
    output logic [31:0] dq_i, // data level at the pins
    output logic [3:0] dm_i, // mask pin levels
    output logic [3:0] dqs_i, // strobe p levels
    output logic [3:0] dqs_n_i, // strobe n levels
    output logic [3:0] dq_ecc_i, // ecc data levels
    output logic [2:0] misc_i, // ecc mask, ecc strobe p, ecc strobe n
    output logic [2:0] tmatch_i // strobe match returns
);
    int seed = 32'h0000_7a31; // own stream, fixed
    logic [63:0] pat_ff = 64'h0000_0000_0000_0000; // fresh pattern per cycle
    ////////////////////////////////////////////////////////////////
    // released lines never hold their last value: new pattern each edge
    always @(posedge sys_clk) begin
        pat_ff <= {$random(seed), $random(seed)};
    end
    // a driven lane shows the controller's value, an idle one the pattern
    always_comb begin
        dq_i = pat_ff[31:0];
        for (int k = 0; k < 4; k++) begin
            if (dq_oe[k]) begin
                dq_i[8*k+:8] = dq_o[8*k+:8];
            end
        end
    end
    assign dm_i = pat_ff[35:32];
    assign dqs_i = pat_ff[39:36];
    assign dqs_n_i = pat_ff[43:40];
    assign dq_ecc_i = pat_ff[47:44];
    assign misc_i = pat_ff[50:48];
    assign tmatch_i = pat_ff[53:51];
endmodule

// File: tb/ddr_ctrl_status_interrupt_shell_test.sv
`timescale 1ns/10ps
// top bench: random events and data, per-cycle model of the irq levels
module ddr_ctrl_status_interrupt_shell_test
    import dcs_pkg::*;
;
    localparam int PW = 32; // phy width under test
    logic sys_clk = 1'b0;
    logic rstn, psel, penable, pwrite, pready, pslverr, wr_en, ecc_wr_mask, chk_on, cal_seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, exp_evt;
    logic pll_lock_raw, fabric_pll_locked_in, ecc_event, fab_proto_err, ddr_pll_locked, err;
    logic pll_locked_irq, pll_lock_lost_irq, ecc_irq, io_calibration_done_irq;
    logic fabric_protocol_error_irq, ecc_any, fic_any;
    logic [PW-1:0] wr_data, rd_data, dq_i, dq_o;
    logic [3:0] wr_mask, dq_oe, dm_i, dm_o, dm_oe, dqs_i, dqs_o, dqs_oe, dqs_n_i, dqs_n_o, dqs_n_oe;
    logic [3:0] ecc_wr_data, ecc_rd_data, dq_ecc_i, dq_ecc_o;
    logic dq_ecc_oe, dm_ecc_i, dm_ecc_o, dm_ecc_oe, dqs_ecc_i, dqs_ecc_o, dqs_ecc_oe;
    logic dqs_ecc_n_i, dqs_ecc_n_o, dqs_ecc_n_oe, strobe_match_fifo0_in, strobe_match_fifo0_out;
    logic strobe_match_fifo1_in, strobe_match_fifo1_out, strobe_match_ecc_in, strobe_match_ecc_out;
    logic locked_ff, prev_ff; // model of lock status and its last value
    logic [1:0] tm_ff; // model of strobe match launches
    logic oe_ff; // model of lane enable
    logic [PW-1:0] dq_ff; // model of lane drive data
    int lk_ff, lost_ff, ecc_ff, fic_ff, ecc_n_ff; // model hold counters, ecc count
    int err_total, tests_run;
    int seed = 32'h5d6c;
    ////////////////////////////////////////////////////////////////
    dcs_shell #(.PHY_WIDTH(PW)) dut (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pll_lock_raw, .fabric_pll_locked_in, .ecc_event,
        .fab_proto_err, .ddr_pll_locked, .pll_locked_irq, .pll_lock_lost_irq, .ecc_irq,
        .io_calibration_done_irq, .fabric_protocol_error_irq, .wr_en, .wr_data, .wr_mask,
        .rd_data, .ecc_wr_data, .ecc_wr_mask, .ecc_rd_data, .dq_i, .dq_o, .dq_oe, .dm_i, .dm_o,
        .dm_oe, .dqs_i, .dqs_o, .dqs_oe, .dqs_n_i, .dqs_n_o, .dqs_n_oe, .dq_ecc_i, .dq_ecc_o,
        .dq_ecc_oe, .dm_ecc_i, .dm_ecc_o, .dm_ecc_oe, .dqs_ecc_i, .dqs_ecc_o, .dqs_ecc_oe,
        .dqs_ecc_n_i, .dqs_ecc_n_o, .dqs_ecc_n_oe, .strobe_match_fifo0_in,
        .strobe_match_fifo0_out, .strobe_match_fifo1_in, .strobe_match_fifo1_out,
        .strobe_match_ecc_in, .strobe_match_ecc_out);
    dcs_far_model far (.sys_clk(sys_clk), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .dm_i(dm_i),
        .dqs_i(dqs_i), .dqs_n_i(dqs_n_i), .dq_ecc_i(dq_ecc_i),
        .misc_i({dm_ecc_i, dqs_ecc_i, dqs_ecc_n_i}),
        .tmatch_i({strobe_match_ecc_in, strobe_match_fifo1_in, strobe_match_fifo0_in}));
    ////////////////////////////////////////////////////////////////
    always #2.5 sys_clk = ~sys_clk; // 200 mhz
    // reload on an event, else count down; cleared in reset
    function automatic int hold(input logic ev, input int n);
        return (rstn !== 1'b1) ? 0 : ev ? IRQ_HOLD_CYCLES : (n > 0 ? n - 1 : 0);
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wrap_up;
        if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // reference model of the status and irq levels
    always @(posedge sys_clk) begin
        locked_ff <= rstn & pll_lock_raw;
        prev_ff <= rstn & locked_ff;
        lk_ff <= hold(locked_ff & !prev_ff, lk_ff);
        lost_ff <= hold(!locked_ff & prev_ff, lost_ff);
        ecc_ff <= hold(ecc_event, ecc_ff);
        fic_ff <= hold(fab_proto_err, fic_ff);
        tm_ff <= rstn ? {strobe_match_fifo1_in, strobe_match_fifo0_in} : 2'b00;
        if (rstn && ecc_event) ecc_n_ff <= ecc_n_ff + 1;
        ecc_any <= ecc_any | ecc_event;
        fic_any <= fic_any | fab_proto_err;
        oe_ff <= rstn & wr_en;
        dq_ff <= !rstn ? '0 : wr_en ? wr_data : dq_ff;
        wr_en <= 1'($random(seed)); wr_data <= $random(seed); wr_mask <= 4'($random(seed));
        ecc_wr_data <= 4'($random(seed)); ecc_wr_mask <= 1'($random(seed));
        // fabric lock holds still while a transfer may read it
        fabric_pll_locked_in <= psel ? fabric_pll_locked_in : 1'($random(seed));
    end
    // compare mid-cycle, once everything has settled
    always @(negedge sys_clk) if (chk_on) begin
        check("lock status", ddr_pll_locked, locked_ff);
        check("lock irq", pll_locked_irq, lk_ff != 0);
        check("lost irq", pll_lock_lost_irq, lost_ff != 0);
        check("ecc irq", ecc_irq, ecc_ff != 0);
        check("fic irq", fabric_protocol_error_irq, fic_ff != 0);
        check("match1", strobe_match_fifo1_out, tm_ff[1]);
        check("match0", strobe_match_fifo0_out, tm_ff[0]);
        check("dq enable", dq_oe, {4{oe_ff}});
        check("dq drive", dq_o, dq_ff);
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        wrap_up();
    end
    initial begin
        {rstn, psel, penable, pwrite, pll_lock_raw, ecc_event, fab_proto_err, chk_on} = 8'h00;
        {wr_en, wr_data, wr_mask, ecc_wr_data, ecc_wr_mask, fabric_pll_locked_in} = '0;
        {paddr, pwdata, ecc_n_ff, ecc_any, fic_any, cal_seen} = '0;
        repeat (2) @(posedge sys_clk);
        chk_on <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        check("dq width", $bits(dq_o), PW);
        check("strobe width", $bits(dqs_o), PW / 8);
        check("ecc width", $bits(dq_ecc_o), PW / 8);
        @(posedge sys_clk) pll_lock_raw <= 1'b1;
        for (int i = 0; i < 400; i++) begin
            @(posedge sys_clk);
            ecc_event <= ($random(seed) & 7) == 0;
            fab_proto_err <= ($random(seed) & 15) == 0;
            if (io_calibration_done_irq === 1'b1 && !cal_seen) begin
                cal_seen = 1'b1;
                check("cal delay", i, CAL_CYCLES + 2);
            end
        end
        @(posedge sys_clk);
        ecc_event <= 1'b0; fab_proto_err <= 1'b0;
        check("cal irq seen", cal_seen, 1'b1);
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        check("status", rd, {29'h0, fabric_pll_locked_in, 2'b11});
        apb(1'b0, REG_ECC_CNT, 32'h0000_0000);
        check("ecc count", rd, ecc_n_ff);
        exp_evt = {27'h0, fic_any, 1'b1, ecc_any, 2'b01};
        apb(1'b0, REG_EVENT, 32'h0000_0000);
        check("events", rd, exp_evt);
        apb(1'b1, REG_EVENT, 32'h0000_001F);
        apb(1'b0, REG_EVENT, 32'h0000_0000);
        check("events clear", rd, 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0000_0000);
        check("unmapped err", err, 1'b1);
        check("unmapped data", rd, 32'h0000_0000);
        pll_lock_raw <= 1'b0;
        repeat (10) @(posedge sys_clk);
        apb(1'b0, REG_EVENT, 32'h0000_0000);
        check("lost event", rd, 32'h0000_0002);
        pll_lock_raw <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (12) @(posedge sys_clk);
        wrap_up();
    end
endmodule
